// ### include/ind_mon_params.svh
// named constants for the indicator status monitor
// assumes a 200 MHz core clock and a 32-bit APB register bus
`ifndef IND_MON_PARAMS_SVH
`define IND_MON_PARAMS_SVH

// ==========================================
// sizes
`define IND_COUNT 10
`define IND_IDX_W 4
`define PEND_W 80
`define PEND_IDX_W 7
`define STAMP_W 32

// ==========================================
// timing
`define CLK_PERIOD_NS 5
`define STAMP_RES_NS 1000000
`define STAMP_CYCLES (`STAMP_RES_NS / `CLK_PERIOD_NS)

// ==========================================
// register byte offsets
`define ADDR_CTRL 8'h00
`define ADDR_SRC_CFG 8'h04
`define ADDR_SW_SRC 8'h08
`define ADDR_STATUS 8'h0c
`define ADDR_EVT_STAT 8'h10
`define ADDR_TIME 8'h14

// ==========================================
// field positions and reset values
`define CTRL_SETUP_BIT 0
`define CTRL_FLT_LSB 1
`define CTRL_FLT_MSB 2
`define SRC_SINGLE_LSB 0
`define SRC_OPEN_SW_LSB 10
`define SRC_CLOSE_SW_LSB 20
`define SW_OPEN_LSB 0
`define SW_CLOSE_LSB 10
`define FLT_RESET 2'h3
`define ZERO32 32'h0000_0000

`endif

// ### include/ind_mon_pkg.sv
// types shared by the indicator status monitor files
// assumes ind_mon_params.svh is on the include path
`include "ind_mon_params.svh"

package ind_mon_pkg;

  // ==========================================
  // decoded indicator status codes
  typedef enum logic [1:0] {
    ST_INTER = 2'b00,
    ST_OPEN = 2'b01,
    ST_CLOSED = 2'b10,
    ST_BAD = 2'b11
  } ind_status_t;

  // event emitter states
  typedef enum logic [0:0] {
    EV_IDLE = 1'b0,
    EV_HOLD = 1'b1
  } emit_state_t;

  // one time-stamped event towards the common event buffer
  typedef struct packed {
    logic [`STAMP_W-1:0] stamp_ms;
    logic [`IND_IDX_W-1:0] ind_idx;
    ind_status_t cond;
    logic is_on;
  } evt_t;

endpackage : ind_mon_pkg

// ### rtl/event_stamp_timer.sv
// millisecond time base for event stamps
// assumes a free-running core clock at the documented rate
`timescale 1ns/1ps
`include "ind_mon_params.svh"

module event_stamp_timer #(
  parameter int TICK_CYCLES = `STAMP_CYCLES
) (
  input wire logic core_clk,
  input wire logic nrst,
  output logic [`STAMP_W-1:0] ms_count
);

  logic [31:0] div_reg; // cycles within the current millisecond

  // ==========================================
  // divider: one tick per millisecond
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      div_reg <= `ZERO32;
    end else if (div_reg == 32'(TICK_CYCLES - 1)) begin
      div_reg <= `ZERO32;
    end else begin
      div_reg <= div_reg + 32'h0000_0001;
    end
  end

  // millisecond counter, wraps freely
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      ms_count <= `ZERO32;
    end else if (div_reg == 32'(TICK_CYCLES - 1)) begin
      ms_count <= ms_count + 32'h0000_0001;
    end
  end

endmodule : event_stamp_timer

// ### rtl/indicator_decode.sv
// decode of one indicator's open and close inputs with change detect
// assumes inputs are synchronous to core_clk
`timescale 1ns/1ps

module indicator_decode (
  input wire logic core_clk,
  input wire logic nrst,
  input wire logic open_in,
  input wire logic close_in,
  input wire logic single_mode,
  output ind_mon_pkg::ind_status_t status_reg,
  output ind_mon_pkg::ind_status_t prev_reg,
  output logic change_reg
);

  logic eff_close; // close after optional inversion of open
  logic armed_reg; // first load after reset is not a change
  ind_mon_pkg::ind_status_t status_next;

  // ==========================================
  // decode
  always_comb begin
    eff_close = single_mode ? ~open_in : close_in;
    case ({eff_close, open_in})
      2'b00: status_next = ind_mon_pkg::ST_INTER;
      2'b01: status_next = ind_mon_pkg::ST_OPEN;
      2'b10: status_next = ind_mon_pkg::ST_CLOSED;
      default: status_next = ind_mon_pkg::ST_BAD;
    endcase
  end

  // status, previous status and change pulse each cycle
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      status_reg <= ind_mon_pkg::ST_INTER;
      prev_reg <= ind_mon_pkg::ST_INTER;
      change_reg <= 1'b0;
      armed_reg <= 1'b0;
    end else begin
      status_reg <= status_next;
      prev_reg <= status_reg;
      armed_reg <= 1'b1;
      change_reg <= armed_reg && (status_next != status_reg);
    end
  end

endmodule : indicator_decode

// ### rtl/indicator_status_monitor.sv
// indicator status monitor: ten indicators, event stream, APB slave
// assumes APB master on core_clk and a common event buffer taking
// one event per accepted evt_ready handshake
//
// Contract
// - status codes: 0 inter, 1 open, 2 closed, 3 bad
// - neither input active gives intermediate
// - both inputs active gives bad
// - open input one means open
// - close input one means closed
// - single-input mode: close is inverted open
// - ON and OFF events for four conditions
// - every event stamped at 1 ms resolution
// - events only on status changes
// - user filter: ON, OFF or both stored
// - ten independent indicators with own events
// - status only, no control outputs
// - settings change only in setup phase
`timescale 1ns/1ps
`include "ind_mon_params.svh"

module indicator_status_monitor #(
  parameter int MS_CYCLES = `STAMP_CYCLES
) (
  input wire logic core_clk,
  input wire logic nrst,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // hardware status inputs
  input wire logic [`IND_COUNT-1:0] hw_open_in,
  input wire logic [`IND_COUNT-1:0] hw_close_in,
  // decoded status, two bits per indicator
  output logic [2*`IND_COUNT-1:0] ind_status,
  // event stream to the common event buffer
  output ind_mon_pkg::evt_t evt_word,
  output logic evt_valid,
  input wire logic evt_ready
);

  // ==========================================
  // declarations
  logic setup_reg; // setup phase, settings writable
  logic [1:0] flt_reg; // bit0 keep ON, bit1 keep OFF
  logic [`IND_COUNT-1:0] single_reg; // single-input mode
  logic [`IND_COUNT-1:0] open_sw_sel_reg; // open from software
  logic [`IND_COUNT-1:0] close_sw_sel_reg; // close from software
  logic [`IND_COUNT-1:0] sw_open_reg; // software switch values
  logic [`IND_COUNT-1:0] sw_close_reg;
  logic [`IND_COUNT-1:0] open_src; // selected open source
  logic [`IND_COUNT-1:0] close_src; // selected close source
  ind_mon_pkg::ind_status_t stat [`IND_COUNT];
  ind_mon_pkg::ind_status_t prev [`IND_COUNT];
  logic [`IND_COUNT-1:0] chg; // change pulses
  logic [`STAMP_W-1:0] ms_now; // current time in ms
  logic [`STAMP_W-1:0] stamp_reg [`IND_COUNT]; // time of last change
  logic [`PEND_W-1:0] pend_reg; // pending events
  logic [`PEND_W-1:0] pend_set; // new events this cycle
  logic [`PEND_W-1:0] pend_clr; // event taken this cycle
  logic [`PEND_IDX_W-1:0] pick; // lowest pending index
  logic pick_any; // something pending
  ind_mon_pkg::emit_state_t state_reg;
  logic wr_en; // write takes effect
  logic rd_en; // first access cycle; read data captured on reads
  logic mapped; // address decodes
  logic [31:0] rd_val; // read mux

  // ==========================================
  // source selection
  // per indicator choose pin or software switch
  always_comb begin
    for (int i = 0; i < `IND_COUNT; i++) begin
      open_src[i] = open_sw_sel_reg[i] ? sw_open_reg[i] : hw_open_in[i];
      close_src[i] = close_sw_sel_reg[i] ? sw_close_reg[i] : hw_close_in[i];
    end
  end

  // ==========================================
  // indicator instances
  // ten independent decoders
  generate
    for (genvar g = 0; g < `IND_COUNT; g++) begin : g_ind
      indicator_decode u_dec (
        .core_clk(core_clk),
        .nrst(nrst),
        .open_in(open_src[g]),
        .close_in(close_src[g]),
        .single_mode(single_reg[g]),
        .status_reg(stat[g]),
        .prev_reg(prev[g]),
        .change_reg(chg[g])
      );
    end
  endgenerate

  // status output, indication only
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      ind_status <= '0;
    end else begin
      for (int i = 0; i < `IND_COUNT; i++) begin
        ind_status[2*i +: 2] <= stat[i];
      end
    end
  end

  // ==========================================
  // time base
  event_stamp_timer #(
    .TICK_CYCLES(MS_CYCLES)
  ) u_timer (
    .core_clk(core_clk),
    .nrst(nrst),
    .ms_count(ms_now)
  );

  // capture the stamp of each change
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      for (int i = 0; i < `IND_COUNT; i++) begin
        stamp_reg[i] <= `ZERO32;
      end
    end else begin
      for (int i = 0; i < `IND_COUNT; i++) begin
        if (chg[i]) begin
          stamp_reg[i] <= ms_now;
        end
      end
    end
  end

  // ==========================================
  // event generation
  // index = indicator*8 + condition*2 + on
  // a change gives OFF for the old and ON for the new condition
  always_comb begin
    pend_set = '0;
    for (int i = 0; i < `IND_COUNT; i++) begin
      // events are dropped during the setup phase
      if (chg[i] && !setup_reg) begin
        if (flt_reg[1]) begin
          pend_set[i*8 + 2*int'(prev[i])] = 1'b1;
        end
        if (flt_reg[0]) begin
          pend_set[i*8 + 2*int'(stat[i]) + 1] = 1'b1;
        end
      end
    end
  end

  // lowest pending event goes first
  always_comb begin
    pick = '0;
    pick_any = 1'b0;
    for (int j = `PEND_W - 1; j >= 0; j--) begin
      if (pend_reg[j]) begin
        pick = `PEND_IDX_W'(j);
        pick_any = 1'b1;
      end
    end
  end

  // bit cleared when the emitter loads it
  always_comb begin
    pend_clr = '0;
    if (state_reg == ind_mon_pkg::EV_IDLE && pick_any) begin
      pend_clr[pick] = 1'b1;
    end
  end

  // pending flags; a new event wins over the clear
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      pend_reg <= '0;
    end else begin
      pend_reg <= (pend_reg & ~pend_clr) | pend_set;
    end
  end

  // ==========================================
  // event emitter
  // holds each event until the buffer takes it
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      state_reg <= ind_mon_pkg::EV_IDLE;
      evt_valid <= 1'b0;
      evt_word <= '0;
    end else begin
      case (state_reg)
        ind_mon_pkg::EV_IDLE: begin
          if (pick_any) begin
            evt_word.stamp_ms <= stamp_reg[pick[6:3]];
            evt_word.ind_idx <= pick[6:3];
            evt_word.cond <= ind_mon_pkg::ind_status_t'(pick[2:1]);
            evt_word.is_on <= pick[0];
            evt_valid <= 1'b1;
            state_reg <= ind_mon_pkg::EV_HOLD;
          end
        end
        ind_mon_pkg::EV_HOLD: begin
          // released when the buffer accepts
          if (evt_ready) begin
            evt_valid <= 1'b0;
            state_reg <= ind_mon_pkg::EV_IDLE;
          end
        end
        default: begin
          evt_valid <= 1'b0;
          state_reg <= ind_mon_pkg::EV_IDLE;
        end
      endcase
    end
  end

  // ==========================================
  // apb slave
  // one wait state: pready rises in the second access cycle
  assign wr_en = psel && penable && pready && pwrite;
  assign rd_en = psel && penable && !pready;

  // address decode
  always_comb begin
    mapped = 1'b1;
    rd_val = `ZERO32;
    case (paddr)
      `ADDR_CTRL: begin
        rd_val[`CTRL_SETUP_BIT] = setup_reg;
        rd_val[`CTRL_FLT_MSB:`CTRL_FLT_LSB] = flt_reg;
      end
      `ADDR_SRC_CFG: begin
        rd_val[`SRC_SINGLE_LSB +: `IND_COUNT] = single_reg;
        rd_val[`SRC_OPEN_SW_LSB +: `IND_COUNT] = open_sw_sel_reg;
        rd_val[`SRC_CLOSE_SW_LSB +: `IND_COUNT] = close_sw_sel_reg;
      end
      `ADDR_SW_SRC: begin
        rd_val[`SW_OPEN_LSB +: `IND_COUNT] = sw_open_reg;
        rd_val[`SW_CLOSE_LSB +: `IND_COUNT] = sw_close_reg;
      end
      `ADDR_STATUS: begin
        rd_val[2*`IND_COUNT-1:0] = ind_status;
      end
      `ADDR_EVT_STAT: begin
        rd_val[0] = pick_any;
        rd_val[1] = evt_valid;
      end
      `ADDR_TIME: begin
        rd_val = ms_now;
      end
      default: begin
        mapped = 1'b0;
      end
    endcase
  end

  // handshake, read data and error flag
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      pready <= 1'b0;
      prdata <= `ZERO32;
      pslverr <= 1'b0;
    end else begin
      pready <= rd_en;
      pslverr <= rd_en && !mapped;
      if (rd_en && !pwrite) begin
        prdata <= rd_val;
      end
    end
  end

  // control: setup phase flag and event filter
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      setup_reg <= 1'b0;
      flt_reg <= `FLT_RESET;
    end else if (wr_en && paddr == `ADDR_CTRL) begin
      setup_reg <= pwdata[`CTRL_SETUP_BIT];
      if (setup_reg) begin
        flt_reg <= pwdata[`CTRL_FLT_MSB:`CTRL_FLT_LSB];
      end
    end
  end

  // source settings, frozen outside setup
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      single_reg <= '0;
      open_sw_sel_reg <= '0;
      close_sw_sel_reg <= '0;
    end else if (wr_en && paddr == `ADDR_SRC_CFG && setup_reg) begin
      single_reg <= pwdata[`SRC_SINGLE_LSB +: `IND_COUNT];
      open_sw_sel_reg <= pwdata[`SRC_OPEN_SW_LSB +: `IND_COUNT];
      close_sw_sel_reg <= pwdata[`SRC_CLOSE_SW_LSB +: `IND_COUNT];
    end
  end

  // software switch values, live signals
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      sw_open_reg <= '0;
      sw_close_reg <= '0;
    end else if (wr_en && paddr == `ADDR_SW_SRC) begin
      sw_open_reg <= pwdata[`SW_OPEN_LSB +: `IND_COUNT];
      sw_close_reg <= pwdata[`SW_CLOSE_LSB +: `IND_COUNT];
    end
  end

endmodule : indicator_status_monitor

// ### sim/contact_model.sv
// auxiliary contact model for ten switchgear objects
// assumes pos holds one two-bit status code per object
`timescale 1ns/1ps
`include "ind_mon_params.svh"

module contact_model (
  input wire logic core_clk,
  input wire logic [2*`IND_COUNT-1:0] pos,
  output logic [`IND_COUNT-1:0] hw_open_in,
  output logic [`IND_COUNT-1:0] hw_close_in
);
  // contacts follow the commanded position one clock later, active high
  always_ff @(posedge core_clk) begin
    for (int i = 0; i < `IND_COUNT; i++) begin
      hw_open_in[i] <= pos[2*i];
      hw_close_in[i] <= pos[2*i+1];
    end
  end
endmodule : contact_model

// ### sim/ind_mon_props.sv
// checker for the indicator status monitor ports
// assumes it is bound onto every indicator_status_monitor instance
`timescale 1ns/1ps
`include "ind_mon_params.svh"

module ind_mon_props (
  input wire logic core_clk,
  input wire logic nrst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic [`IND_COUNT-1:0] hw_open_in,
  input wire logic [`IND_COUNT-1:0] hw_close_in,
  input wire logic [2*`IND_COUNT-1:0] ind_status,
  input wire ind_mon_pkg::evt_t evt_word,
  input wire logic evt_valid,
  input wire logic evt_ready
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!nrst);

  // ==========================================
  // quiet counter: cycles since an input moved or a register was written
  logic [2:0] quiet;
  logic [2*`IND_COUNT-1:0] in_last;
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      quiet <= 3'h0;
      in_last <= '0;
    end else begin
      in_last <= {hw_open_in, hw_close_in};
      if ({hw_open_in, hw_close_in} != in_last || (psel && pwrite)) begin
        quiet <= 3'h0;
      end else if (quiet != 3'h7) begin
        quiet <= quiet + 3'h1;
      end
    end
  end

  // ==========================================
  // assertions
  a_status_quiet: assert property (quiet > 3'h4 |-> $stable(ind_status))
    else $error("status moved with steady inputs");
  a_valid_hold: assert property (evt_valid && !evt_ready |=> evt_valid)
    else $error("event dropped before taken");
  a_word_hold: assert property (evt_valid && !evt_ready |=> $stable(evt_word))
    else $error("event word changed while waiting");
  a_valid_gap: assert property (evt_valid && evt_ready |=> !evt_valid)
    else $error("no gap after taken event");
  a_idx_range: assert property (evt_valid |-> evt_word.ind_idx < 4'ha)
    else $error("event index out of range");
  a_one_wait: assert property (psel && penable && !pready |=> pready)
    else $error("access not answered after one wait");
  a_ready_pulse: assert property (pready |=> !pready)
    else $error("ready longer than one cycle");
  a_err_ready: assert property (pslverr |-> pready && psel && penable)
    else $error("error outside an access");
endmodule : ind_mon_props

bind indicator_status_monitor ind_mon_props ind_mon_props_i (.core_clk, .nrst, .psel,
  .penable, .pwrite, .pready, .pslverr, .hw_open_in, .hw_close_in, .ind_status,
  .evt_word, .evt_valid, .evt_ready);

// ### sim/indicator_status_monitor_bench.sv
// self-checking bench for the indicator status monitor
// assumes package, design, checker and contact model compiled first
`timescale 1ns/1ps
`include "ind_mon_params.svh"

module indicator_status_monitor_bench;
  logic core_clk = 1'b0;
  logic nrst = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic [2*`IND_COUNT-1:0] pos = '0; // commanded object positions
  logic [`IND_COUNT-1:0] hw_open_in;
  logic [`IND_COUNT-1:0] hw_close_in;
  logic [2*`IND_COUNT-1:0] ind_status;
  ind_mon_pkg::evt_t evt_word;
  logic evt_valid;
  logic evt_ready = 1'b0;
  ind_mon_pkg::evt_t got[$]; // events taken by the sink
  int errors = 0;
  int n_checks = 0;
  logic [31:0] rd; // last read data
  logic err; // last error flag

  initial forever #2.5 core_clk = ~core_clk;

  indicator_status_monitor #(.MS_CYCLES(10)) indicator_status_monitor_i (.core_clk, .nrst,
    .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .hw_open_in,
    .hw_close_in, .ind_status, .evt_word, .evt_valid, .evt_ready);
  contact_model contact_model_i (.core_clk, .pos, .hw_open_in, .hw_close_in);

  // event sink: takes each event one cycle after it appears
  always @(posedge core_clk) begin
    if (evt_valid === 1'b1 && evt_ready) got.push_back(evt_word);
    evt_ready <= evt_valid === 1'b1 && !evt_ready;
  end

  task automatic chk(input logic [31:0] g, input logic [31:0] e, input string what);
    n_checks++;
    if (g !== e) begin
      errors++;
      $display("BAD %0t %s got %h want %h", $time, what, g, e);
    end
  endtask : chk

  task automatic test_done;
    $display("checks %0d mismatches %0d", n_checks, errors);
    if (errors == 0 && n_checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : test_done

  // one apb transfer; holds the request until pready
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int n;
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge core_clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge core_clk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (n >= 50) begin
      errors++;
      test_done();
    end
    @(posedge core_clk);
  endtask : apb

  // wait for n events and until the event stream has been idle 20 cycles, bounded
  task automatic settle(input int n);
    int q;
    q = 0;
    for (int k = 0; k < 1000 && (got.size() < n || q < 20); k++) begin
      @(posedge core_clk);
      q = (evt_valid === 1'b1) ? 0 : q + 1;
    end
    if (got.size() < n || q < 20) begin
      errors++;
      test_done();
    end
  endtask : settle

  task automatic t_decode;
    logic [31:0] e;
    for (int k = 0; k < 4; k++) begin
      e = 32'h0000_0000;
      for (int i = 0; i < 10; i++) begin
        pos[2*i +: 2] <= 2'((i + k) % 4);
        e[2*i +: 2] = 2'((i + k) % 4);
      end
      settle(0);
      chk(32'(ind_status), e, "status pins");
      apb(1'b0, `ADDR_STATUS, 32'h0000_0000);
      chk(rd, e, "status reg");
    end
    $display("decode done");
  endtask : t_decode

  task automatic t_events;
    ind_mon_pkg::evt_t f;
    ind_mon_pkg::evt_t o;
    pos <= {10{2'h1}};
    settle(0);
    for (int c = 2; c < 6; c++) begin
      got.delete();
      pos[7:6] <= 2'(c % 4);
      settle(2);
      chk(32'(got.size()), 32'h0000_0002, "event count");
      f = got[0].is_on ? got[1] : got[0];
      o = got[0].is_on ? got[0] : got[1];
      chk(32'({f.ind_idx, f.cond, f.is_on}), 32'({4'h3, 2'((c - 1) % 4), 1'b0}), "off");
      chk(32'({o.ind_idx, o.cond, o.is_on}), 32'({4'h3, 2'(c % 4), 1'b1}), "on");
      chk(f.stamp_ms, o.stamp_ms, "pair stamp");
    end
    apb(1'b0, `ADDR_TIME, 32'h0000_0000);
    chk(32'(rd - o.stamp_ms < 32'h0000_0006), 32'h0000_0001, "stamp age");
    $display("events done");
  endtask : t_events

  task automatic t_filter;
    for (int fl = 1; fl < 4; fl++) begin
      apb(1'b1, `ADDR_CTRL, 32'h0000_0001);
      apb(1'b1, `ADDR_CTRL, 32'(fl * 2 + 1));
      apb(1'b1, `ADDR_CTRL, 32'(fl * 2));
      got.delete();
      pos[11:10] <= fl % 2 ? 2'h2 : 2'h1;
      settle(fl == 3 ? 2 : 1);
      chk(32'(got.size()), fl == 3 ? 32'h0000_0002 : 32'h0000_0001, "kept");
      chk(32'(got[0].is_on), 32'(fl == 1), "kind");
    end
    $display("filter done");
  endtask : t_filter

  task automatic t_setup;
    apb(1'b1, `ADDR_SRC_CFG, 32'h0000_0001);
    apb(1'b0, `ADDR_SRC_CFG, 32'h0000_0000);
    chk(rd, 32'h0000_0000, "cfg locked");
    apb(1'b1, `ADDR_CTRL, 32'h0000_0001);
    got.delete();
    pos[13:12] <= 2'h2;
    settle(0);
    apb(1'b1, `ADDR_CTRL, 32'h0000_0006);
    pos <= pos;
    settle(0);
    chk(32'(got.size()), 32'h0000_0000, "quiet");
    apb(1'b0, `ADDR_EVT_STAT, 32'h0000_0000);
    chk(rd, 32'h0000_0000, "nothing pending");
    apb(1'b0, `ADDR_CTRL, 32'h0000_0000);
    chk(rd, 32'h0000_0006, "ctrl readback");
    rd = 32'h0000_1234;
    apb(1'b0, 8'h20, 32'h0000_0000);
    chk(32'(err), 32'h0000_0001, "unmapped");
    $display("setup done");
  endtask : t_setup

  task automatic t_sources;
    apb(1'b1, `ADDR_CTRL, 32'h0000_0001);
    apb(1'b1, `ADDR_SRC_CFG, 32'h0020_0801);
    apb(1'b1, `ADDR_CTRL, 32'h0000_0006);
    pos[3:0] <= 4'h3;
    apb(1'b1, `ADDR_SW_SRC, 32'h0000_0002);
    settle(0);
    chk(32'(ind_status[3:0]), 32'h0000_0005, "single open, sw open");
    pos[3:0] <= 4'h2;
    apb(1'b1, `ADDR_SW_SRC, 32'h0000_0800);
    settle(0);
    chk(32'(ind_status[3:0]), 32'h0000_000a, "single closed, sw closed");
    $display("sources done");
  endtask : t_sources

  initial begin
    repeat (10) @(posedge core_clk);
    nrst <= 1'b1;
    @(posedge core_clk);
    t_decode();
    t_events();
    t_filter();
    t_setup();
    t_sources();
    test_done();
  end
endmodule : indicator_status_monitor_bench
